/* File: logic/osac_ctrl.sv */
`include "osac_consts.svh"
`default_nettype none
module osac_ctrl (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Bus slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready_in,
  output logic hready_out,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // Configuration.
  input wire logic [1:0] bank_low_wait_cfg,
  input wire logic [1:0] bank_high_wait_cfg,
  input wire logic core_endian_config_out,
  input wire logic stall_req,
  // Low bank macro.
  output logic low_select,
  output logic low_write_enable_n,
  output logic [`OSAC_AW-1:0] low_addr,
  output logic [31:0] low_wdata,
  output logic [3:0] low_byte_select,
  output logic low_clock_in,
  input wire logic [31:0] low_rdata,
  // High bank macro.
  output logic high_select,
  output logic high_write_enable_n,
  output logic [`OSAC_AW-1:0] high_addr,
  output logic [31:0] high_wdata,
  output logic [3:0] high_byte_select,
  output logic high_clock_in,
  input wire logic [31:0] high_rdata
);
  osac_pkg::osac_state_type state_q;
  logic [31:0] haddr_q;
  logic hwrite_q;
  logic [2:0] hsize_q;
  logic bank_q;
  logic [1:0] waits_q;
  logic [1:0] wcnt_q;
  logic endian_q1;
  logic endian_q2;
  logic stall_q1;
  logic stall_q2;
  logic [31:0] rdata_q;
  logic sel_q;
  logic tail_q;
  logic rd1_q;
  logic rd2_q;
  logic rbank1_q;
  logic rbank2_q;
  logic hit_low;
  logic hit_high;
  logic take;
  logic access;
  logic [3:0] lanes;
  logic [31:0] wswap;
  logic [31:0] rraw;
  logic [1:0] cfg_pick;
  logic [1:0] waits_d;

  ////////////////////////////////////////////////////////////////////////////
  // Endian and stall are static straps from other logic; synchronise anyway.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      endian_q1 <= 1'b0;
      endian_q2 <= 1'b0;
      stall_q1 <= 1'b0;
      stall_q2 <= 1'b0;
    end
    else
    begin
      endian_q1 <= core_endian_config_out;
      endian_q2 <= endian_q1;
      stall_q1 <= stall_req;
      stall_q2 <= stall_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode onto the two banks.
  assign hit_low = (haddr >= `OSAC_BANK_LOW_BASE) &&
                   (haddr < `OSAC_BANK_LOW_BASE + `OSAC_BANK_BYTES);
  assign hit_high = (haddr >= `OSAC_BANK_HIGH_BASE) &&
                    (haddr < `OSAC_BANK_HIGH_BASE + `OSAC_BANK_BYTES);
  assign take = hsel && hready_in && htrans[1] && (hit_low || hit_high) &&
                !stall_q2 && (state_q != osac_pkg::OSAC_WAIT);

  // Latency code per bank; the undefined code rounds up to two waits.
  assign cfg_pick = hit_high ? bank_high_wait_cfg : bank_low_wait_cfg;
  always_comb
  begin
    case (cfg_pick)
      `OSAC_WAIT_NONE: waits_d = 2'h0;
      `OSAC_WAIT_ONE: waits_d = 2'h1;
      `OSAC_WAIT_UNDEF: waits_d = 2'h2;
      default: waits_d = 2'h2;
    endcase
  end

  // Address phase capture.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      haddr_q <= 32'h0;
      hwrite_q <= 1'b0;
      hsize_q <= 3'h0;
      bank_q <= 1'b0;
      waits_q <= `OSAC_WAIT_RESET;
    end
    else if (take)
    begin
      haddr_q <= haddr;
      hwrite_q <= hwrite;
      hsize_q <= hsize;
      bank_q <= hit_high;
      waits_q <= waits_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data phase sequencer: each wait state is one more register stage.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= osac_pkg::OSAC_IDLE;
      wcnt_q <= 2'h0;
    end
    else
    begin
      case (state_q)
        osac_pkg::OSAC_IDLE, osac_pkg::OSAC_DATA:
        begin
          if (take && waits_d != 2'h0)
          begin
            state_q <= osac_pkg::OSAC_WAIT;
            wcnt_q <= waits_d;
          end
          else if (take)
            state_q <= osac_pkg::OSAC_DATA;
          else
            state_q <= osac_pkg::OSAC_IDLE;
        end
        osac_pkg::OSAC_WAIT:
        begin
          if (!stall_q2)
          begin
            wcnt_q <= wcnt_q - 2'h1;
            if (wcnt_q == 2'h1)
              state_q <= osac_pkg::OSAC_DATA;
          end
        end
        default: state_q <= osac_pkg::OSAC_IDLE;
      endcase
    end
  end

  // Marks the data phase that closes a waited transfer, whose access has already fired.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tail_q <= 1'b0;
    else
      tail_q <= (state_q == osac_pkg::OSAC_WAIT) && (wcnt_q == 2'h1) && !stall_q2;
  end

  // The macro fires once per transfer: in a zero-wait data phase, or in the last wait cycle.
  // Firing twice would rewrite the word and double the read power for nothing.
  assign access = ((state_q == osac_pkg::OSAC_DATA) && !tail_q) ||
                  ((state_q == osac_pkg::OSAC_WAIT) && wcnt_q == 2'h1 && !stall_q2);

  // Byte lanes from size and low address; big endian mirrors lane order.
  always_comb
  begin
    case (hsize_q)
      3'h0: lanes = 4'h1 << haddr_q[1:0];
      3'h1: lanes = haddr_q[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
    if (endian_q2)
      lanes = {lanes[0], lanes[1], lanes[2], lanes[3]};
  end
  assign wswap = endian_q2 ? {hwdata[7:0], hwdata[15:8], hwdata[23:16], hwdata[31:24]} : hwdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bank ports; writes use the data phase data, hence one-cycle write timing.
  osac_bank_port u_low (
    .clock(clock),
    .rst_n(rst_n),
    .access(access && !bank_q),
    .write(hwrite_q),
    .word_addr(haddr_q[`OSAC_WORD_LSB +: `OSAC_AW]),
    .wdata(wswap),
    .byte_sel(lanes),
    .mem_select(low_select),
    .mem_write_enable_n(low_write_enable_n),
    .mem_addr(low_addr),
    .mem_wdata(low_wdata),
    .mem_byte_select(low_byte_select),
    .mem_clock_in(low_clock_in)
  );
  osac_bank_port u_high (
    .clock(clock),
    .rst_n(rst_n),
    .access(access && bank_q),
    .write(hwrite_q),
    .word_addr(haddr_q[`OSAC_WORD_LSB +: `OSAC_AW]),
    .wdata(wswap),
    .byte_sel(lanes),
    .mem_select(high_select),
    .mem_write_enable_n(high_write_enable_n),
    .mem_addr(high_addr),
    .mem_wdata(high_wdata),
    .mem_byte_select(high_byte_select),
    .mem_clock_in(high_clock_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read return; outputs are zero when not our transfer so they can be ORed.
  // The macro answers one edge after its select, so the read and its bank are carried along.
  // A later transfer may already have moved bank_q by the time the data comes back.
  assign rraw = rbank2_q ? high_rdata : low_rdata;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0;
      sel_q <= 1'b0;
      rd1_q <= 1'b0;
      rd2_q <= 1'b0;
      rbank1_q <= 1'b0;
      rbank2_q <= 1'b0;
    end
    else
    begin
      rd1_q <= access && !hwrite_q;
      rbank1_q <= bank_q;
      rd2_q <= rd1_q;
      rbank2_q <= rbank1_q;
      sel_q <= rd2_q;
      rdata_q <= rd2_q ?
                 (endian_q2 ? {rraw[7:0], rraw[15:8], rraw[23:16], rraw[31:24]} : rraw) : 32'h0;
    end
  end
  assign hrdata = sel_q ? rdata_q : 32'h0;
  assign hresp = `OSAC_HRESP_OKAY;
  assign hready_out = !(state_q == osac_pkg::OSAC_WAIT) && !stall_q2;
endmodule
`default_nettype wire

/* File: logic/osac_consts.svh */
// How it works
// - Full AHB slave, any master, reads/writes
// - One slave port steers to two banks
// - Banks at 0x11028000 and 0x11040000
// - Bus address becomes word address; data moves
// - Two-bit setting picks zero, one, two waits
// - Reset leaves zero wait states
// - Each bank has its own wait setting
// - Each wait state adds one pipeline stage
// - Endian input: 0 little, 1 big
// - Stall input high halts the controller
// - Runs on the bus main clock
// - Async active-low reset clears all logic
// - No DMA handshake; plain bus transfers
// - Idle memory address, data, strobes hold still
// - Idle bank select stays low
// - Unselected bank write enable stays high
// - Inactive bank memory clock held high
`ifndef OSAC_CONSTS_SVH
`define OSAC_CONSTS_SVH
`define OSAC_BANK_LOW_BASE 32'h11028000
`define OSAC_BANK_HIGH_BASE 32'h11040000
`define OSAC_BANK_BYTES 32'h00018000
`define OSAC_WORD_LSB 2
`define OSAC_AW 15
`define OSAC_WAIT_NONE 2'h0
`define OSAC_WAIT_ONE 2'h1
`define OSAC_WAIT_UNDEF 2'h2
`define OSAC_WAIT_RESET 2'h0
`define OSAC_HTRANS_NONSEQ 2'h2
`define OSAC_HRESP_OKAY 2'h0
`endif

/* File: logic/osac_pkg.sv */
`default_nettype none
package osac_pkg;
  // Access phase of the controller.
  typedef enum logic [1:0] {
    OSAC_IDLE = 2'b00,
    OSAC_WAIT = 2'b01,
    OSAC_DATA = 2'b10
  } osac_state_type;
endpackage
`default_nettype wire

/* File: logic/osac_bank_port.sv */
`include "osac_consts.svh"
`default_nettype none
module osac_bank_port (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Request from the controller core.
  input wire logic access,
  input wire logic write,
  input wire logic [`OSAC_AW-1:0] word_addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] byte_sel,
  // Memory macro pins.
  output logic mem_select,
  output logic mem_write_enable_n,
  output logic [`OSAC_AW-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_byte_select,
  output logic mem_clock_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Address, data and lanes change only on an access so the macro sees no toggles.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_addr <= '0;
      mem_wdata <= '0;
      mem_byte_select <= 4'h0;
    end
    else if (access)
    begin
      mem_addr <= word_addr;
      mem_wdata <= write ? wdata : mem_wdata;
      mem_byte_select <= write ? byte_sel : mem_byte_select;
    end
  end

  // Select is low and write enable in read position unless this bank works.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_select <= 1'b0;
      mem_write_enable_n <= 1'b1;
    end
    else
    begin
      mem_select <= access;
      mem_write_enable_n <= !(access && write);
    end
  end

  // Gated memory clock: parked high while idle, pulses low then high on use.
  // A latch-free gate: the low phase follows the bus clock only while selected.
  assign mem_clock_in = mem_select ? clock : 1'b1;
endmodule
`default_nettype wire

/* File: verification/osac_ctrl_assertions.sv */
`include "osac_consts.svh"
`default_nettype none
module osac_chk (
  // Bus side.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready_in,
  input wire logic hready_out,
  input wire logic [1:0] hresp,
  input wire logic [31:0] hrdata,
  // Settings and macro pins.
  input wire logic [1:0] bank_low_wait_cfg,
  input wire logic stall_req,
  input wire logic low_select,
  input wire logic low_write_enable_n,
  input wire logic [`OSAC_AW-1:0] low_addr,
  input wire logic [31:0] low_wdata,
  input wire logic low_clock_in,
  input wire logic high_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A low-bank transfer taken once the two stall flops have drained.
  sequence s_tk;
    !stall_req [*3] ##0 hsel && hready_in && htrans[1] && hready_out && haddr[31:17] == 15'h0881;
  endsequence
  property p_lat0; s_tk ##0 bank_low_wait_cfg == 2'h0 |=> hready_out; endproperty
  property p_lat1; s_tk ##0 bank_low_wait_cfg == 2'h1 |=> !hready_out ##1 hready_out; endproperty
  property p_lat2; s_tk ##0 bank_low_wait_cfg[1] |=> !hready_out [*2] ##1 hready_out; endproperty
  property p_rd; s_tk ##0 !hwrite |-> ##[1:3] low_select && low_write_enable_n; endproperty
  property p_idle; !low_select |-> low_write_enable_n && low_clock_in; endproperty
  property p_hold; !low_select ##1 !low_select |-> $stable(low_addr) && $stable(low_wdata); endproperty
  property p_okay; hresp == `OSAC_HRESP_OKAY; endproperty
  property p_zero; !hsel [*6] |-> hrdata == 32'h0; endproperty
  property p_stall; stall_req [*4] |-> !low_select && !high_select; endproperty
  a_lat0: assert property (p_lat0) else $error("zero wait latency wrong");
  a_lat1: assert property (p_lat1) else $error("one wait latency wrong");
  a_lat2: assert property (p_lat2) else $error("two wait latency wrong");
  a_rd: assert property (p_rd) else $error("read not sent to bank");
  a_idle: assert property (p_idle) else $error("idle bank strobes wrong");
  a_hold: assert property (p_hold) else $error("idle bank pins moved");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_zero: assert property (p_zero) else $error("read data not zero");
  a_stall: assert property (p_stall) else $error("bank selected in stall");
endmodule
bind osac_ctrl osac_chk osac_chk_inst (.*);
`default_nettype wire

/* File: verification/osac_mem_model.sv */
`default_nettype none
module osac_mem_model (
  // Clock.
  input wire logic clock,
  // Macro pins.
  input wire logic sel,
  input wire logic we_n,
  input wire logic [14:0] addr,
  input wire logic [31:0] wd,
  input wire logic [3:0] bs,
  output logic [31:0] rd
);
  logic [31:0] m [0:31];
  // Idle edges invert the read bus, so stale data shows again only after an even number of idle edges.
  always @(posedge clock)
  begin
    if (sel && !we_n)
      for (int i = 0; i < 4; i++)
        if (bs[i]) m[addr[4:0]][8*i+:8] <= wd[8*i+:8];
    rd <= sel ? m[addr[4:0]] : ~rd;
  end
endmodule
`default_nettype wire

/* File: verification/tb_osac_ctrl.sv */
`include "osac_consts.svh"
`default_nettype none
module tb_osac_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, hready_in = 1, hready_out, ok;
  logic core_endian_config_out = 0, stall_req = 0, low_select, high_select;
  logic low_write_enable_n, high_write_enable_n, low_clock_in, high_clock_in;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, low_rdata, high_rdata, low_wdata, high_wdata;
  logic [1:0] htrans = 0, hresp, bank_low_wait_cfg = 0, bank_high_wait_cfg = 0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] low_byte_select, high_byte_select, lbs;
  logic [14:0] low_addr, high_addr;
  int n_fail = 0, tests_run = 0, nsel = 0, nw, k0;
  osac_ctrl osac_ctrl_inst (.*);
  osac_mem_model osac_mem_model_inst (.clock(clock), .sel(low_select), .we_n(low_write_enable_n),
    .addr(low_addr), .wd(low_wdata), .bs(low_byte_select), .rd(low_rdata));
  osac_mem_model osac_mem_model_inst2 (.clock(clock), .sel(high_select), .we_n(high_write_enable_n),
    .addr(high_addr), .wd(high_wdata), .bs(high_byte_select), .rd(high_rdata));
  always #50 clock = ~clock;
  // Count bank selects and keep the last low-bank lane mask.
  always @(posedge clock)
  begin
    nsel <= nsel + int'(low_select | high_select);
    if (low_select) lbs <= low_byte_select;
  end
  ////////////////////////////////////////////////////////////////
  task chk(string s, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task results;
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One bus transfer; counts wait cycles and notes whether d was ever read back.
  task xfer(logic [31:0] a, logic w, logic [2:0] sz, logic [31:0] d);
    int k;
    @(negedge clock);
    hsel = 1;
    haddr = a;
    htrans = `OSAC_HTRANS_NONSEQ;
    hwrite = w;
    hsize = sz;
    #1;
    for (k = 0; k < 20 && !hready_out; k++) @(negedge clock);
    @(posedge clock);
    @(negedge clock);
    hwdata = d;
    hsel = 0;
    htrans = 2'h0;
    nw = 0;
    ok = 0;
    k = 0;
    for (int i = 0; i < 8; i++)
    begin
      #1;
      if (!hready_out && k == 0) nw++;
      else k = 1;
      if (hrdata === d) ok = 1;
      @(negedge clock);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Every latency code on the low bank, then the high bank with its own code.
  task s_lat;
    for (int c = 0; c < 4; c++)
    begin
      bank_low_wait_cfg = c[1:0];
      xfer(32'h11028000 + 4 * c, 1, 2, 32'hA5000000 + c);
      chk("waits", c == 0 ? 0 : (c == 1 ? 1 : 2), nw);
      xfer(32'h11028000 + 4 * c, 0, 2, 32'hA5000000 + c);
      chk("rdata", 1, ok);
    end
    bank_low_wait_cfg = 2'h0;
    bank_high_wait_cfg = 2'h3;
    xfer(32'h11040010, 1, 2, 32'h5A5A0001);
    chk("high waits", 2, nw);
    xfer(32'h1103FFFC, 1, 2, 32'h3C3C0002);
    chk("low waits", 0, nw);
    xfer(32'h11040010, 0, 2, 32'h5A5A0001);
    chk("high rdata", 1, ok);
    xfer(32'h1103FFFC, 0, 2, 32'h3C3C0002);
    chk("top rdata", 1, ok);
  endtask
  // Byte zero lands in the top lane when big endian.
  task s_endian;
    for (int e = 1; e >= 0; e--)
    begin
      core_endian_config_out = e[0];
      repeat (3) @(negedge clock);
      xfer(32'h11028040, 1, 0, 32'h000000AB);
      chk("lanes", e ? 4'h8 : 4'h1, lbs);
    end
  endtask
  // Well below the low bank and just past the high bank nothing is selected.
  task s_unmapped;
    k0 = nsel;
    xfer(32'h11000000, 0, 2, 32'h0);
    xfer(32'h11058000, 0, 2, 32'h0);
    chk("unmapped sel", k0, nsel);
  endtask
  // A stalled transfer waits, then completes once released.
  task s_stall;
    stall_req = 1;
    repeat (3) @(negedge clock);
    k0 = nsel;
    fork
      xfer(32'h11028000, 0, 2, 32'hA5000000);
      begin
        repeat (8) @(negedge clock);
        chk("stall sel", k0, nsel);
        stall_req = 0;
      end
    join
    chk("resume", 1, ok);
  endtask
  ////////////////////////////////////////////////////////////////
  // Reset state, then the scenarios.
  initial
  begin
    repeat (15) @(negedge clock);
    chk("select", 0, low_select | high_select);
    chk("we_n", 1, low_write_enable_n & high_write_enable_n);
    chk("clock_in", 1, low_clock_in & high_clock_in);
    chk("hrdata", 0, hrdata);
    @(negedge clock);
    rst_n = 1;
    s_lat;
    s_endian;
    s_unmapped;
    s_stall;
    results;
  end
  // A hang is cut short well past the expected run time.
  initial
  begin
    #3000000;
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
